// ---- mcg_chk_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcg_chk (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sleep_req_i,
  input wire logic clk_en_o,
  input wire logic sleep_o,
  input wire logic disabled_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  stat_gated_a: assert property (disabled_o |-> !clk_en_o) else $error("ungated");
  gate_first_a: assert property ($rose(disabled_o) |-> !$past(clk_en_o))
    else $error("status early");
  // gating state lasts one cycle only
  gate_lag_a: assert property (!clk_en_o && !disabled_o |=> clk_en_o || disabled_o)
    else $error("status stuck");
  stat_next_a: assert property ($fell(clk_en_o) |=> disabled_o) else $error("lag");
  wake_clear_a: assert property ($rose(clk_en_o) |-> !disabled_o) else $error("wake");
  clear_wake_a: assert property ($fell(disabled_o) |-> clk_en_o) else $error("clear");
  sleep_cause_a: assert property (sleep_o |-> sleep_req_i) else $error("sleep");
endmodule // mcg_chk
bind mcg_clock_ctrl mcg_chk chk_u (.*);
`default_nettype wire

// ---- mcg_clock_ctrl.sv ----
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mcg_defs.svh"
module mcg_clock_ctrl
  import mcg_pkg::*;
#(
  parameter logic [1:0] VARIANT = `MCG_VARIANT_FULL
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_req_i,
  output logic clk_en_o,
  output logic sleep_o,
  output logic disabled_o
);
  logic disreq_q;
  logic disreq_d;
  logic slign_q;
  logic slign_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic gate_en;
  logic off_stat;
  logic wr_acc;
  logic rd_acc;
  logic hit;

  // bit 3 only exists where the variant keeps it
  function automatic logic slign_exists(input logic [1:0] v);
    slign_exists = (v != `MCG_VARIANT_NOSLEEP);
  endfunction

  assign hit = (paddr_i == `MCG_ADDR_CTRL);
  assign wr_acc = psel_i && penable_i && pwrite_i && hit && pstrb_i[0];
  assign rd_acc = psel_i && !penable_i && !pwrite_i;

  always_comb begin
    disreq_d = disreq_q;
    slign_d = slign_q;
    rdata_d = rdata_q;
    if (wr_acc) begin
      disreq_d = pwdata_i[`MCG_BIT_DISREQ];
      if (slign_exists(VARIANT)) begin
        slign_d = pwdata_i[`MCG_BIT_SLIGN];
      end
    end
    // read data latched in setup, returned in the zero-wait access phase
    if (rd_acc) begin
      rdata_d = `MCG_ZERO_WORD;
      if (paddr_i == `MCG_ADDR_CTRL) begin
        rdata_d[`MCG_BIT_DISREQ] = disreq_q;
        rdata_d[`MCG_BIT_DISSTAT] = off_stat;
        rdata_d[`MCG_BIT_SLIGN] = slign_exists(VARIANT) ? slign_q : 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      disreq_q <= `MCG_RESET_CTRL;
      slign_q <= `MCG_RESET_SLIGN;
      rdata_q <= `MCG_ZERO_WORD;
    end else begin
      disreq_q <= disreq_d;
      slign_q <= slign_d;
      rdata_q <= rdata_d;
    end
  end

  mcg_gate_seq u_seq (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .off_req_i(disreq_q),
    .clk_en_o(gate_en),
    .off_stat_o(off_stat)
  );

  assign prdata_o = rdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;
  assign clk_en_o = gate_en;
  assign disabled_o = off_stat;
  // sleep is combinational so the request reaches the module without delay
  assign sleep_o = sleep_req_i && (VARIANT == `MCG_VARIANT_FULL) && !slign_q;
endmodule // mcg_clock_ctrl
`default_nettype wire

// ---- mcg_defs.svh ----
`ifndef MCG_DEFS_SVH
`define MCG_DEFS_SVH
`define MCG_ADDR_CTRL 12'h000
`define MCG_ADDR_WORD 12'h004
`define MCG_BIT_DISREQ 0
`define MCG_BIT_DISSTAT 1
`define MCG_BIT_SLIGN 3
`define MCG_RESET_CTRL 1'b0
`define MCG_RESET_SLIGN 1'b0
`define MCG_ZERO_WORD 32'h0000_0000
`define MCG_VARIANT_FULL 2'h0
`define MCG_VARIANT_NOSLEEP 2'h1
`define MCG_VARIANT_STORE 2'h2
`endif

// ---- mcg_gate_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mcg_defs.svh"
module mcg_gate_seq
  import mcg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic off_req_i,
  output logic clk_en_o,
  output logic off_stat_o
);
  mcg_state_t state_q;
  mcg_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MCG_RUN: begin
        if (off_req_i) begin
          state_d = MCG_GATING;
        end
      end
      // gate first, report one cycle later so status never precedes the stop
      MCG_GATING: begin
        state_d = off_req_i ? MCG_OFF : MCG_RUN;
      end
      MCG_OFF: begin
        if (!off_req_i) begin
          state_d = MCG_RUN;
        end
      end
      default: begin
        state_d = MCG_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= MCG_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign clk_en_o = (state_q == MCG_RUN);
  assign off_stat_o = (state_q == MCG_OFF);
endmodule // mcg_gate_seq
`default_nettype wire

// ---- mcg_pkg.sv ----
`default_nettype none
package mcg_pkg;
  typedef enum logic [2:0] {
    MCG_RUN = 3'b001,
    MCG_GATING = 3'b010,
    MCG_OFF = 3'b100
  } mcg_state_t;
endpackage
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mcg_defs.svh"
module tb_top;
  logic clk_sys_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, sleep_req_i = 0;
  logic pready_o, pslverr_o, clk_en_o, sleep_o, disabled_o, ev;
  logic [11:0] paddr_i = 12'h000;
  logic [3:0] pstrb_i = 4'hf;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rv;
  int failures = 0, num_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  logic [31:0] prdata_ns;
  logic sleep_ns, disabled_ns;
  mcg_clock_ctrl dut_u (.*);
  // second copy without the sleep-ignore bit, same bus and sleep input
  mcg_clock_ctrl #(.VARIANT(`MCG_VARIANT_NOSLEEP)) dut_ns_u (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_ns),
    .pready_o(),
    .pslverr_o(),
    .sleep_req_i(sleep_req_i),
    .clk_en_o(),
    .sleep_o(sleep_ns),
    .disabled_o(disabled_ns)
  );
  task ck(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // edge first, so a release never meets a new request in one step
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rv = prdata_o;
    ev = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task wt(input logic v);
    for (int i = 0; i < 9 && disabled_o !== v; i++) @(posedge clk_sys_i);
  endtask
  task tally_and_finish;
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #5000;
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1;
    xf(1, 12'h000, 32'h9);
    wt(1);
    ck("gate", 2'b01, {clk_en_o, disabled_o});
    ck("gate_ns", 1, disabled_ns);
    xf(0, 12'h000, 0);
    ck("ctrl", 32'hb, rv);
    ck("ctrl_ns", 32'h3, prdata_ns);
    sleep_req_i <= 1;
    #1 ck("sleep", 0, sleep_o);
    xf(1, 12'h000, 32'h2);
    wt(0);
    #1 ck("wake", 2'b11, {clk_en_o, sleep_o});
    ck("sleep_ns", 0, sleep_ns);
    xf(0, 12'h000, 0);
    ck("ctrl", 0, rv);
    xf(0, 12'h004, 0);
    ck("unmapped", 1, {rv[30:0], ev});
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
